// *** logic/itdoc_pkg.sv ***
// Constants for the input trim and DC offset correction control block.
// Assumes one sampling-rate clock and the 4-wire serial configuration port.
package itdoc_pkg;
  // Register offsets on the serial configuration port
  localparam logic [14:0] ADDR_INPUT_IMBALANCE_TRIM = 15'h0014;
  localparam logic [14:0] ADDR_OFFSET_FILTER_MODE = 15'h003D;
  // Reset values
  localparam logic [7:0] RST_INPUT_IMBALANCE_TRIM = 8'h00;
  localparam logic [7:0] RST_OFFSET_FILTER_MODE = 8'h00;
  // Field positions
  localparam int AMP_TRIM_LSB = 4;
  localparam int PHASE_TRIM_LSB = 0;
  localparam int TIME_CONST_LSB = 1;
  localparam int CORR_ON_BIT = 0;
  // Reserved amplitude code, largest phase step count
  localparam logic [2:0] AMP_CODE_RESERVED = 3'h4;
  localparam logic [2:0] PHASE_STEPS_MAX = 3'h7;
  // Time constants at 250 MSPS, in ns, per setting 00..11
  localparam int TAU_NS_00 = 17000;
  localparam int TAU_NS_01 = 130000;
  localparam int TAU_NS_10 = 1100000;
  localparam int TAU_NS_11 = 8400000;
  localparam int SAMPLE_PERIOD_NS = 4;
  // Nearest power-of-two averaging shift for each time constant
  localparam logic [4:0] SHIFT_00 = 5'h0C;
  localparam logic [4:0] SHIFT_01 = 5'h0F;
  localparam logic [4:0] SHIFT_10 = 5'h12;
  localparam logic [4:0] SHIFT_11 = 5'h15;
  localparam int SHIFT_MAX = 21;
  // Serial frame layout: R/W bit, 15 address bits, 8 data bits
  localparam logic [4:0] FRAME_HDR_LAST = 5'h0F;
  localparam logic [4:0] FRAME_LAST = 5'h17;
endpackage : itdoc_pkg

// *** logic/itdoc_ctrl.sv ***
// Input imbalance trim registers, serial configuration slave and DC
// offset correction high-pass filter. Assumes clk_sys is the sample clock
// and the serial pins are asynchronous to it (sclk well below clk_sys/4).
`timescale 1ns/1ps
module itdoc_ctrl #(
  parameter int SAMPLE_W = 14
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial configuration port
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Analog trim controls
  output logic [2:0] amplitude_trim,
  output logic amp_pos_leg_up,
  output logic [1:0] amp_step,
  output logic [3:0] phase_trim,
  output logic phase_cap_neg,
  output logic [2:0] phase_cap_steps,
  // Sample stream
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  output logic out_valid,
  output logic signed [SAMPLE_W-1:0] sample_out
);
  localparam int ACC_W = SAMPLE_W + itdoc_pkg::SHIFT_MAX + 1;

  logic [7:0] input_imbalance_trim;
  logic [7:0] offset_filter_mode;
  logic [1:0] offset_filter_time_const;
  logic offset_correction_on;
  logic [2:0] csb_sync;
  logic [2:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic [4:0] bit_cnt;
  logic [22:0] shreg;
  logic [7:0] dout;
  logic rd_phase;
  logic sclk_rise;
  logic sclk_fall;
  logic [4:0] shift;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] est_wide;
  logic signed [SAMPLE_W-1:0] est;

  // Clamp a wider difference to the sample range
  function automatic logic signed [SAMPLE_W-1:0] itdoc_sat(
    input logic signed [SAMPLE_W:0] v
  );
    logic signed [SAMPLE_W:0] hi;
    logic signed [SAMPLE_W:0] lo;
    hi = (SAMPLE_W+1)'((1 <<< (SAMPLE_W-1)) - 1);
    lo = -hi - (SAMPLE_W+1)'(1);
    if (v > hi)
    begin
      itdoc_sat = hi[SAMPLE_W-1:0];
    end
    else if (v < lo)
    begin
      itdoc_sat = lo[SAMPLE_W-1:0];
    end
    else
    begin
      itdoc_sat = v[SAMPLE_W-1:0];
    end
  endfunction : itdoc_sat

  // Register fields
  assign amplitude_trim = input_imbalance_trim[itdoc_pkg::AMP_TRIM_LSB +: 3];
  assign phase_trim = input_imbalance_trim[itdoc_pkg::PHASE_TRIM_LSB +: 4];
  assign offset_filter_time_const =
    offset_filter_mode[itdoc_pkg::TIME_CONST_LSB +: 2];
  assign offset_correction_on = offset_filter_mode[itdoc_pkg::CORR_ON_BIT];

  // Amplitude decode; the reserved code is held at no trim for safety
  always_comb
  begin
    amp_pos_leg_up = amplitude_trim[2];
    if (amplitude_trim == itdoc_pkg::AMP_CODE_RESERVED)
    begin
      amp_step = 2'h0;
    end
    else
    begin
      amp_step = amplitude_trim[1:0];
    end
  end

  // Phase decode: 8 and up loads the negative input, steps capped at 7
  always_comb
  begin
    phase_cap_neg = phase_trim[3];
    if (!phase_trim[3])
    begin
      phase_cap_steps = phase_trim[2:0];
    end
    else if (phase_trim == 4'hF)
    begin
      phase_cap_steps = itdoc_pkg::PHASE_STEPS_MAX;
    end
    else
    begin
      phase_cap_steps = phase_trim[2:0] + 3'h1;
    end
  end

  // Two-stage synchronisers; only stages 1 and 2 feed logic
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      csb_sync <= 3'h7;
      sclk_sync <= 3'h0;
      sdi_sync <= 2'h0;
    end
    else
    begin
      csb_sync <= {csb_sync[1:0], spi_csb_n};
      sclk_sync <= {sclk_sync[1:0], spi_sclk};
      sdi_sync <= {sdi_sync[0], spi_sdi};
    end
  end

  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2] & ~csb_sync[1];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2] & ~csb_sync[1];

  // Frame shifter; reads return the whole stored byte, reserved bits too
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || csb_sync[1])
    begin
      bit_cnt <= 5'h00;
      shreg <= 23'h000000;
      dout <= 8'h00;
      rd_phase <= 1'b0;
    end
    else if (sclk_rise)
    begin
      shreg <= {shreg[21:0], sdi_sync[1]};
      if (bit_cnt != 5'h1F)
      begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (bit_cnt == itdoc_pkg::FRAME_HDR_LAST && shreg[14])
      begin
        rd_phase <= 1'b1;
        unique case ({shreg[13:0], sdi_sync[1]})
          itdoc_pkg::ADDR_INPUT_IMBALANCE_TRIM: dout <= input_imbalance_trim;
          itdoc_pkg::ADDR_OFFSET_FILTER_MODE: dout <= offset_filter_mode;
          default: dout <= 8'h00;
        endcase
      end
    end
    else if (sclk_fall && rd_phase && bit_cnt > 5'h10)
    begin
      dout <= {dout[6:0], 1'b0};
    end
  end

  assign spi_sdo = dout[7];
  assign spi_sdo_oe = rd_phase;

  // Register writes commit on the last data bit of a write frame
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      input_imbalance_trim <= itdoc_pkg::RST_INPUT_IMBALANCE_TRIM;
      offset_filter_mode <= itdoc_pkg::RST_OFFSET_FILTER_MODE;
    end
    else if (sclk_rise && !csb_sync[1] &&
             bit_cnt == itdoc_pkg::FRAME_LAST && !shreg[22])
    begin
      if (shreg[21:7] == itdoc_pkg::ADDR_INPUT_IMBALANCE_TRIM)
      begin
        input_imbalance_trim <= {shreg[6:0], sdi_sync[1]};
      end
      if (shreg[21:7] == itdoc_pkg::ADDR_OFFSET_FILTER_MODE)
      begin
        offset_filter_mode <= {shreg[6:0], sdi_sync[1]};
      end
    end
  end

  // Time constant setting to averaging shift, about log2 of tau/sample period
  always_comb
  begin
    unique case (offset_filter_time_const)
      2'b00: shift = itdoc_pkg::SHIFT_00;
      2'b01: shift = itdoc_pkg::SHIFT_01;
      2'b10: shift = itdoc_pkg::SHIFT_10;
      2'b11: shift = itdoc_pkg::SHIFT_11;
    endcase
  end

  assign est_wide = acc >>> shift;
  assign est = est_wide[SAMPLE_W-1:0];

  // Recursive DC average; frozen while correction is off
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      acc <= '0;
    end
    else if (sample_valid && offset_correction_on)
    begin
      acc <= acc + ACC_W'(sample_in) - ACC_W'(est);
    end
  end

  // Output: corrected or passed straight through
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      sample_out <= '0;
    end
    else
    begin
      out_valid <= sample_valid;
      if (sample_valid)
      begin
        if (offset_correction_on)
        begin
          sample_out <= itdoc_sat((SAMPLE_W+1)'(sample_in) -
                                  (SAMPLE_W+1)'(est));
        end
        else
        begin
          sample_out <= sample_in;
        end
      end
    end
  end

  a_bypass_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sample_valid && !offset_correction_on |=>
    out_valid && sample_out == $past(sample_in))
    else $error("bypass sample not passed unchanged");

  a_corr_applied: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sample_valid && offset_correction_on |=>
    sample_out == itdoc_sat((SAMPLE_W+1)'($past(sample_in)) -
                            (SAMPLE_W+1)'($past(est))))
    else $error("corrected sample wrong");

  a_reset_zero: assert property (@(posedge clk_sys)
    !rst_n |=> input_imbalance_trim == 8'h00 &&
    offset_filter_mode == 8'h00 && !offset_correction_on)
    else $error("registers not cleared by reset");

  a_amp_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
    amplitude_trim == 3'h4 |-> amp_step == 2'h0)
    else $error("reserved amplitude code drives trim");

  a_phase_side: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_trim != 4'h0 |-> phase_cap_steps != 3'h0 &&
    phase_cap_neg == (phase_trim > 4'h7))
    else $error("phase trim decode wrong");

  a_tc_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
    offset_filter_time_const == 2'b00 |-> shift == 5'h0C)
    else $error("fastest time constant shift wrong");

  c_write_mode: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(offset_correction_on));
  c_read_frame: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rd_phase));
  c_slow_tc: cover property (@(posedge clk_sys) disable iff (!rst_n)
    offset_correction_on && offset_filter_time_const == 2'b11 &&
    sample_valid);
endmodule : itdoc_ctrl

// *** bench/itdoc_host.sv ***
// Configuration master model driving the serial port of the trim block.
// Assumes clk_sys is the sample clock; frame timing counts its falls.
`timescale 1ns/1ps
module itdoc_host (
  // Clock
  input wire logic clk_sys,
  // Serial port
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  output logic spi_csb_n,
  output logic spi_sclk,
  output logic spi_sdi
);
  // Frame select idles high, serial clock parked low
  initial
  begin
    spi_csb_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end

  // One 24-bit frame; six clocks a half period, above the minimum
  task xfer(input logic rw, input logic [14:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [23:0] f;
    f = {rw, a, d};
    if (a == itdoc_pkg::ADDR_INPUT_IMBALANCE_TRIM)
      f[7] = 1'b0;
    if (a == itdoc_pkg::ADDR_OFFSET_FILTER_MODE)
      f[7:3] = 5'h00;
    q = 8'h00;
    @(negedge clk_sys);
    spi_csb_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      spi_sdi = f[i];
      repeat (6) @(negedge clk_sys);
      // Only the last eight rises are kept; an undriven line reads inverted
      q = {q[6:0], spi_sdo_oe ? spi_sdo : ~spi_sdo};
      spi_sclk = 1'b1;
      repeat (6) @(negedge clk_sys);
      spi_sclk = 1'b0;
    end
    repeat (6) @(negedge clk_sys);
    spi_csb_n = 1'b1;
    spi_sdi = ~spi_sdi; // Released line must not show a stale bit
    repeat (8) @(negedge clk_sys);
  endtask : xfer
endmodule : itdoc_host

// *** bench/testbench.sv ***
// Self-checking bench for the trim and offset correction block.
// Assumes the host model owns the serial pins, the bench the samples.
`timescale 1ns/1ps
module testbench;
  logic clk_sys;
  logic rst_n;
  logic spi_csb_n;
  logic spi_sclk;
  logic spi_sdi;
  logic spi_sdo;
  logic spi_sdo_oe;
  logic [2:0] amplitude_trim;
  logic amp_pos_leg_up;
  logic [1:0] amp_step;
  logic [3:0] phase_trim;
  logic phase_cap_neg;
  logic [2:0] phase_cap_steps;
  logic sample_valid;
  logic signed [13:0] sample_in;
  logic out_valid;
  logic signed [13:0] sample_out;
  logic [7:0] q;
  int n_fail = 0;
  int samples_checked = 0;
  int oe_cycles = 0;

  // Device under test and its configuration master
  itdoc_ctrl #(.SAMPLE_W(14)) u_itdoc_ctrl (.clk_sys(clk_sys),
    .rst_n(rst_n), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .amplitude_trim(amplitude_trim), .amp_pos_leg_up(amp_pos_leg_up),
    .amp_step(amp_step), .phase_trim(phase_trim),
    .phase_cap_neg(phase_cap_neg), .phase_cap_steps(phase_cap_steps),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .out_valid(out_valid), .sample_out(sample_out));
  itdoc_host u_itdoc_host (.clk_sys(clk_sys), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi));

  // Cycles with the serial output driven, to tell read frames from writes
  always @(negedge clk_sys)
  begin
    if (spi_sdo_oe === 1'b1)
      oe_cycles++;
  end

  // Exact value compare
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Filter output compare; the estimate settles only approximately
  task chk_rng(input string name, input int lo, input int hi,
    input logic signed [13:0] got);
    samples_checked++;
    if ((^got === 1'bx) || got < lo || got > hi)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  // Constant samples back to back, then out_valid of the last result is checked
  task feed(input int n, input logic signed [13:0] x);
    repeat (n)
    begin
      @(negedge clk_sys);
      sample_valid = 1'b1;
      sample_in = x;
    end
    @(negedge clk_sys);
    sample_valid = 1'b0;
    chk("out_valid", 16'h0001, 16'(out_valid));
  endtask : feed

  task t_reset;
    u_itdoc_host.xfer(1'b1, itdoc_pkg::ADDR_INPUT_IMBALANCE_TRIM, 8'h00, q);
    chk("trim_rd", 16'(itdoc_pkg::RST_INPUT_IMBALANCE_TRIM),
      16'(q));
    u_itdoc_host.xfer(1'b1, itdoc_pkg::ADDR_OFFSET_FILTER_MODE, 8'h00, q);
    chk("mode_rd", 16'(itdoc_pkg::RST_OFFSET_FILTER_MODE),
      16'(q));
    chk("phase_trim", 16'h0000, 16'(phase_trim));
  endtask : t_reset

  // Every amplitude and phase code, written then read back
  task t_trim;
    logic [3:0] c;
    logic [7:0] d;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      d = {1'b0, c[2:0], c};
      u_itdoc_host.xfer(1'b0, itdoc_pkg::ADDR_INPUT_IMBALANCE_TRIM, d, q);
      u_itdoc_host.xfer(1'b1, itdoc_pkg::ADDR_INPUT_IMBALANCE_TRIM, 8'h00, q);
      chk("trim_rd", 16'(d), 16'(q));
      chk("amp_code", 16'(c[2:0]), 16'(amplitude_trim));
      chk("phase_code", 16'(c), 16'(phase_trim));
      chk("amp_up", 16'(c[2]), 16'(amp_pos_leg_up));
      chk("amp_step", (c[2:0] > 4) ? 16'(c[2:0] - 4) : (c[2:0] < 4) ?
        16'(c[2:0]) : 16'h0000, 16'(amp_step));
      chk("cap_neg", 16'(c[3]), 16'(phase_cap_neg));
      chk("cap_steps", (c < 8) ? 16'(c) : (c == 15) ? 16'h0007 :
        16'(c - 7), 16'(phase_cap_steps));
    end
  endtask : t_trim

  // Unmapped place reads back as zero after a write
  task t_unmapped;
    u_itdoc_host.xfer(1'b0, 15'h0015, 8'h5A, q);
    u_itdoc_host.xfer(1'b1, 15'h0015, 8'h00, q);
    chk("unmapped_rd", 16'h0000, 16'(q));
  endtask : t_unmapped

  // Pass-through, slow then fast decay, then pass-through again
  task t_filter;
    feed(4, 14'sd1000);
    chk("out_off", 16'h03E8, 16'(sample_out));
    u_itdoc_host.xfer(1'b0, itdoc_pkg::ADDR_OFFSET_FILTER_MODE, 8'h03, q);
    feed(4096, 14'sd1000);
    chk_rng("out_slow", 800, 999, sample_out);
    u_itdoc_host.xfer(1'b0, itdoc_pkg::ADDR_OFFSET_FILTER_MODE, 8'h01, q);
    feed(12288, 14'sd1000);
    chk_rng("out_fast", -50, 50, sample_out);
    u_itdoc_host.xfer(1'b0, itdoc_pkg::ADDR_OFFSET_FILTER_MODE, 8'h00, q);
    feed(2, -14'sd500);
    chk("out_off", 16'hFE0C, 16'(sample_out));
    // Settled estimate near 1000 scaled down by the two slowest shifts
    u_itdoc_host.xfer(1'b0, itdoc_pkg::ADDR_OFFSET_FILTER_MODE, 8'h05, q);
    feed(1, 14'sd0);
    chk_rng("out_tc10", -16, -14, sample_out);
    u_itdoc_host.xfer(1'b0, itdoc_pkg::ADDR_OFFSET_FILTER_MODE, 8'h07, q);
    feed(1, 14'sd0);
    chk_rng("out_tc11", -2, -1, sample_out);
  endtask : t_filter

  // Settings written, then a reset in mid-run must clear them all
  task t_midreset;
    int n0;
    n0 = oe_cycles;
    u_itdoc_host.xfer(1'b0, itdoc_pkg::ADDR_INPUT_IMBALANCE_TRIM, 8'h35, q);
    chk("oe_write", 16'h0000, 16'(oe_cycles - n0));
    chk("amp_code", 16'h0003, 16'(amplitude_trim));
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("amp_code", 16'h0000, 16'(amplitude_trim));
    chk("phase_trim", 16'h0000, 16'(phase_trim));
    n0 = oe_cycles;
    u_itdoc_host.xfer(1'b1, itdoc_pkg::ADDR_OFFSET_FILTER_MODE, 8'h00, q);
    chk("mode_rd", 16'h0000, 16'(q));
    chk("oe_read", 16'h0001, 16'(oe_cycles > n0));
    chk("oe_idle", 16'h0000, 16'(spi_sdo_oe));
    feed(1, 14'sd300);
    chk("out_off", 16'h012C, 16'(sample_out));
  endtask : t_midreset

  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Free-running sample clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Main sequence; extra idle after reset flushes the synchronisers
  initial
  begin
    rst_n = 1'b0;
    sample_valid = 1'b0;
    sample_in = 14'sd0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset;
    t_trim;
    t_unmapped;
    t_filter;
    t_midreset;
    conclude;
  end

  // Run needs about 30k cycles; three times that is a hang
  initial
  begin
    #1000000;
    n_fail++;
    conclude;
  end
endmodule : testbench
